//--- design/fdos_map.vh
// Purpose: constants for the fractional output divider and output sync block
// Assumes: 100 MHz system clock; divider clocks arrive as one-cycle enables
// Notes: counts are in cycles of the enable that drives each counter
// Function
// - Fractional divider on each upper output
// - Divide value never below two
// - Integer pre-divider then sigma-delta stage
// - Accept every 20-bit fraction in bands
// - Pin and soft bit merge into request
// - Request holds dividers reset, outputs off
// - Release latched, retimed, each prescaler group's outputs enable together
// - Outputs 0,1,4,5 follow A; others B
// - Equal prescalers give simultaneous start
// - Outputs 4,5 may bypass to references
// - Start-up counters run before calibration
// - Failed calibration retried by sleep/reset toggle
// - Fast ramp: internal delay before calibration
// - Count 64k reference then 64k feedback
// - Calibration 128k cycles, outputs then enable
// - Lock high 2048 to 2560 cycles later
// - Leaving sleep resets all settings; here it restarts only the start-up sequence
`ifndef FDOS_MAP_VH
`define FDOS_MAP_VH
`define FDOS_FRAC_W      20
`define FDOS_INT_W       9
`define FDOS_INT_MIN     9'h002
`define FDOS_REF_CNT     17'h10000
`define FDOS_FB_CNT      17'h10000
`define FDOS_CAL_CNT     18'h20000
`define FDOS_LOCK_CNT    12'h900
`define FDOS_SYNC_BIT    5
`define FDOS_INT_RST     9'h002
`endif

//--- design/fdos_frac_div.v
// Purpose: one fractional output divider channel
// Assumes: in_en is the prescaler output as a one-cycle enable
// Notes: out_tick pulses once per divided period
`timescale 1ns/1ns
`include "fdos_map.vh"
module fdos_frac_div (
	input  wire                     clk,       // System clock
	input  wire                     srst,      // Sync reset
	input  wire                     hold,      // Divider held in reset
	input  wire                     in_en,     // Prescaler enable
	input  wire [`FDOS_INT_W-1:0]   int_div,   // Integer part
	input  wire [`FDOS_FRAC_W-1:0]  frac_word, // Fraction word
	input  wire                     frac_on,   // Fractional path on
	output reg                      out_tick   // Divided pulse
);
	reg  [`FDOS_INT_W:0]    cnt_ff;
	reg  [`FDOS_FRAC_W-1:0] acc_ff;
	reg                     extra_ff;
	wire [`FDOS_FRAC_W:0]   acc_sum;
	wire [`FDOS_INT_W-1:0]  int_eff;
	wire [`FDOS_INT_W:0]    limit;
	wire [`FDOS_INT_W:0]    cnt_inc;
	assign int_eff = (int_div < `FDOS_INT_MIN) ? `FDOS_INT_MIN : int_div;
	assign acc_sum = {1'b0, acc_ff} + {1'b0, frac_word};
	assign cnt_inc = cnt_ff + {{`FDOS_INT_W{1'b0}}, 1'b1};
	assign limit = {1'b0, int_eff} + {{`FDOS_INT_W{1'b0}}, extra_ff};
	always @(posedge clk) begin
		if (srst || hold) begin
			cnt_ff   <= {(`FDOS_INT_W+1){1'b0}};
			acc_ff   <= {`FDOS_FRAC_W{1'b0}};
			extra_ff <= 1'b0;
			out_tick <= 1'b0;
		end else begin
			out_tick <= 1'b0;
			if (in_en) begin
				if (cnt_inc >= limit) begin
					cnt_ff   <= {(`FDOS_INT_W+1){1'b0}};
					out_tick <= 1'b1;
					if (frac_on) begin
						acc_ff   <= acc_sum[`FDOS_FRAC_W-1:0];
						extra_ff <= acc_sum[`FDOS_FRAC_W];
					end else begin
						extra_ff <= 1'b0;
					end
				end else begin
					cnt_ff <= cnt_inc;
				end
			end
		end
	end
endmodule

//--- design/fdos_top.v
// Purpose: output divider, sync and start-up sequencing for a clock generator
// Assumes: all pins synchronous to clk; reference, feedback and PFD as enables
// Notes: outputs are divided pulses with active-low output enables
`timescale 1ns/1ns
`include "fdos_map.vh"
module fdos_top (
	input  wire                       clk,                    // System clock
	input  wire                       srst,                   // Sync reset
	input  wire                       chip_sleep_n,           // Low: power down
	input  wire                       reset_n,                // Device reset pin
	input  wire                       output_align_request_n, // Sync pin, low active
	input  wire [7:0]                 soft_ctrl,              // Control byte, bit 5 sync
	input  wire                       ref_en,                 // Reference tick at PFD
	input  wire                       feedback_clock,         // Feedback tick
	input  wire                       pfd_en,                 // PFD tick
	input  wire                       cal_ok,                 // Calibration success
	input  wire                       prescaler_a,            // Prescaler A tick
	input  wire                       prescaler_b,            // Prescaler B tick
	input  wire [7:0]                 int_tick,               // Integer divider ticks
	input  wire                       pri_ref,                // Primary reference
	input  wire                       sec_ref,                // Secondary reference
	input  wire [3:0]                 frac_out_divider_en,    // Fractional enable 4..7
	input  wire [4*`FDOS_INT_W-1:0]   int_div,                // Integer parts 4..7
	input  wire [4*`FDOS_FRAC_W-1:0]  frac_word,              // Fractions 4..7
	input  wire [1:0]                 bypass_sel,             // Y4,Y5 bypass on
	input  wire [1:0]                 bypass_src,             // 0 primary, 1 secondary
	input  wire [7:0]                 out_enable,             // Per output enable
	output reg  [7:0]                 clk_out,                // Output levels
	output reg  [7:0]                 clk_oe_n,               // Output enable, low drives
	output reg                        divider_hold,           // Dividers in reset
	output reg                        cal_active,             // Calibration running
	output reg                        cal_failed,             // Calibration failed
	output reg                        status_pin_zero         // Lock indicator
);
	localparam ST_REF  = 6'h01;
	localparam ST_FB   = 6'h02;
	localparam ST_CAL  = 6'h04;
	localparam ST_LOCK = 6'h08;
	localparam ST_RUN  = 6'h10;
	localparam ST_FAIL = 6'h20;

	reg  [5:0]  state_ff;
	reg  [17:0] cnt_ff;
	reg         outs_on_ff;
	reg         sleep_d_ff;
	reg         rst_d_ff;
	reg         sync_lat_ff;
	reg         sync_a_ff;
	reg         sync_b_ff;
	wire        sync_req;
	wire        restart;
	wire [3:0]  frac_tick;
	wire [7:0]  div_tick;
	wire [7:0]  ps_sel;

	assign sync_req = ~output_align_request_n | ~soft_ctrl[`FDOS_SYNC_BIT];
	// rising edge of sleep or reset restarts the start-up sequencer
	assign restart = (chip_sleep_n & ~sleep_d_ff) | (reset_n & ~rst_d_ff);
	assign ps_sel = 8'hcc;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_frac
			fdos_frac_div u_div (
				.clk       (clk),
				.srst      (srst),
				.hold      (divider_hold),
				.in_en     (ps_sel[g+4] ? prescaler_b : prescaler_a),
				.int_div   (int_div[g*`FDOS_INT_W +: `FDOS_INT_W]),
				.frac_word (frac_word[g*`FDOS_FRAC_W +: `FDOS_FRAC_W]),
				.frac_on   (frac_out_divider_en[g]),
				.out_tick  (frac_tick[g])
			);
		end
	endgenerate

	generate
		for (g = 0; g < 8; g = g + 1) begin : g_sel
			if (g < 4) begin : g_lo
				assign div_tick[g] = int_tick[g];
			end else if (g < 6) begin : g_mux
				assign div_tick[g] = bypass_sel[g-4] ?
					(bypass_src[g-4] ? sec_ref : pri_ref) :
					(frac_out_divider_en[g-4] ? frac_tick[g-4] : int_tick[g]);
			end else begin : g_hi
				assign div_tick[g] = frac_out_divider_en[g-4] ? frac_tick[g-4]
					: int_tick[g];
			end
		end
	endgenerate

	// Start-up sequencer
	always @(posedge clk) begin
		if (srst || !chip_sleep_n || !reset_n || restart) begin
			state_ff        <= ST_REF;
			cnt_ff          <= 18'h00000;
			outs_on_ff      <= 1'b0;
			cal_active      <= 1'b0;
			cal_failed      <= 1'b0;
			status_pin_zero <= 1'b0;
		end else begin
			case (state_ff)
				ST_REF: begin
					if (ref_en) begin
						if (cnt_ff[16:0] == `FDOS_REF_CNT - 17'h00001) begin
							cnt_ff   <= 18'h00000;
							state_ff <= ST_FB;
						end else begin
							cnt_ff <= cnt_ff + 18'h00001;
						end
					end
				end
				ST_FB: begin
					if (feedback_clock) begin
						if (cnt_ff[16:0] == `FDOS_FB_CNT - 17'h00001) begin
							cnt_ff     <= 18'h00000;
							cal_active <= 1'b1;
							state_ff   <= ST_CAL;
						end else begin
							cnt_ff <= cnt_ff + 18'h00001;
						end
					end
				end
				ST_CAL: begin
					if (pfd_en) begin
						if (cnt_ff == `FDOS_CAL_CNT - 18'h00001) begin
							cnt_ff     <= 18'h00000;
							cal_active <= 1'b0;
							if (cal_ok) begin
								outs_on_ff <= 1'b1;
								state_ff   <= ST_LOCK;
							end else begin
								cal_failed <= 1'b1;
								state_ff   <= ST_FAIL;
							end
						end else begin
							cnt_ff <= cnt_ff + 18'h00001;
						end
					end
				end
				ST_LOCK: begin
					if (pfd_en) begin
						if (cnt_ff[11:0] == `FDOS_LOCK_CNT - 12'h001) begin
							status_pin_zero <= 1'b1;
							state_ff        <= ST_RUN;
						end else begin
							cnt_ff <= cnt_ff + 18'h00001;
						end
					end
				end
				ST_RUN: state_ff <= ST_RUN;
				ST_FAIL: state_ff <= ST_FAIL;
				default: state_ff <= ST_REF;
			endcase
		end
	end

	// Sync latch and prescaler retime
	always @(posedge clk) begin
		// Reset to the idle high level so no false restart follows srst
		sleep_d_ff <= srst ? 1'b1 : chip_sleep_n;
		rst_d_ff   <= srst ? 1'b1 : reset_n;
		if (srst || !chip_sleep_n || !reset_n) begin
			sync_lat_ff  <= 1'b1;
			sync_a_ff    <= 1'b1;
			sync_b_ff    <= 1'b1;
			divider_hold <= 1'b1;
		end else begin
			// latch, then retime to each prescaler
			sync_lat_ff <= sync_req | ~outs_on_ff;
			if (sync_req || !outs_on_ff) begin
				sync_a_ff <= 1'b1;
				sync_b_ff <= 1'b1;
			end else begin
				if (prescaler_a)
					sync_a_ff <= sync_lat_ff;
				if (prescaler_b)
					sync_b_ff <= sync_lat_ff;
			end
			divider_hold <= sync_req | sync_lat_ff;
		end
	end

	// Output stage
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_out
			always @(posedge clk) begin
				if (srst) begin
					clk_out[g]  <= 1'b0;
					clk_oe_n[g] <= 1'b1;
				end else begin
					// enable per group and host bit
					clk_oe_n[g] <= (ps_sel[g] ? sync_b_ff : sync_a_ff) | ~out_enable[g];
					clk_out[g]  <= div_tick[g] & ~(ps_sel[g] ? sync_b_ff : sync_a_ff);
				end
			end
		end
	endgenerate
endmodule

//--- tb/fdos_asserts.sv
// Purpose: timing checks on output sync and start-up sequencing
// Assumes: PFD ticks one cycle wide, sampled on clk
// Notes: bound to fdos_top
`timescale 1ns/1ns
module fdos_asserts (
	input wire       clk,                    // Clock
	input wire       srst,                   // Reset
	input wire       output_align_request_n, // Sync pin
	input wire [7:0] soft_ctrl,              // Soft sync
	input wire       pfd_en,                 // PFD tick
	input wire       prescaler_a,            // Prescaler A tick
	input wire       prescaler_b,            // Prescaler B tick
	input wire [7:0] out_enable,             // Enables
	input wire [7:0] clk_out,                // Outputs
	input wire [7:0] clk_oe_n,               // Drive, low
	input wire       divider_hold,           // Hold
	input wire       cal_active,             // Calibrating
	input wire       status_pin_zero         // Lock
);
	reg [17:0] up_ff;
	reg [17:0] cal_ff;
	reg [11:0] lk_ff;
	// Start-up, calibration and lock cycle counts
	always @(posedge clk) begin
		up_ff <= srst ? 18'h0 : up_ff + {17'h0, ~&up_ff};
		cal_ff <= cal_active ? cal_ff + {17'h0, pfd_en} : 18'h0;
		lk_ff <= cal_active ? 12'h0 : lk_ff + {11'h0, pfd_en & ~&lk_ff};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_pin_sync_off:
		assert property ((!output_align_request_n)[*3] |-> clk_oe_n == 8'hff && divider_hold)
		else $error("sync pin low but outputs on");
	a_soft_sync_off:
		assert property ((!soft_ctrl[5])[*3] |-> clk_oe_n == 8'hff && divider_hold)
		else $error("soft sync low but outputs on");
	a_hold_quiet:
		assert property (divider_hold |=> clk_out == 8'h00)
		else $error("output pulse while dividers held");
	a_hold_oe_off:
		assert property (divider_hold |=> clk_oe_n == 8'hff)
		else $error("output driven while dividers held");
	a_cal_gates_oe:
		assert property (cal_active |-> clk_oe_n == 8'hff)
		else $error("output on during calibration");
	a_cal_length:
		assert property ($fell(cal_active) |-> cal_ff - 18'h1ffff <= 18'h2)
		else $error("calibration length wrong");
	a_boot_count:
		assert property ($rose(cal_active) |-> up_ff >= 18'h20000)
		else $error("calibration began too early");
	a_lock_window:
		assert property ($rose(status_pin_zero) |-> lk_ff >= 12'h800 && lk_ff <= 12'ha00)
		else $error("lock delay out of window");
	a_sync_release:
		assert property ($rose(output_align_request_n) && soft_ctrl[5] && status_pin_zero
			&& out_enable[0] |-> ##[2:6] !clk_oe_n[0])
		else $error("outputs late after sync release");
	a_equal_start:
		assert property ($fell(clk_oe_n[0]) && out_enable == 8'hff
			&& $past(prescaler_a == prescaler_b, 2) |-> clk_oe_n == 8'h00)
		else $error("outputs did not start together");
	a_min_divide:
		assert property (clk_out[6] |=> !clk_out[6])
		else $error("output 6 divided below two");
endmodule
bind fdos_top fdos_asserts chk (
	.clk                    (clk),
	.srst                   (srst),
	.output_align_request_n (output_align_request_n),
	.soft_ctrl              (soft_ctrl),
	.pfd_en                 (pfd_en),
	.prescaler_a            (prescaler_a),
	.prescaler_b            (prescaler_b),
	.out_enable             (out_enable),
	.clk_out                (clk_out),
	.clk_oe_n               (clk_oe_n),
	.divider_hold           (divider_hold),
	.cal_active             (cal_active),
	.status_pin_zero        (status_pin_zero)
);

//--- tb/fdos_far_model.sv
// Purpose: far side: prescaler, reference and start-up tick sources
// Assumes: all ticks one clk cycle wide
// Notes: b_slow halves prescaler B rate
`timescale 1ns/1ns
module fdos_far_model (
	input  wire clk,            // Clock
	input  wire b_slow,         // Prescaler B half rate
	output wire ref_en,         // Reference tick
	output wire feedback_clock, // Feedback tick
	output wire pfd_en,         // PFD tick
	output wire prescaler_a,    // Prescaler A tick
	output wire prescaler_b,    // Prescaler B tick
	output wire pri_ref,        // Primary reference
	output wire sec_ref         // Secondary reference
);
	reg [1:0] ph_ff = 2'h0;
	always @(posedge clk) ph_ff <= ph_ff + 2'h1;
	assign prescaler_a = 1'b1;
	assign prescaler_b = ~b_slow | ph_ff[0];
	assign {ref_en, feedback_clock, pfd_en} = 3'h7;
	assign pri_ref = ph_ff[0];
	assign sec_ref = &ph_ff;
endmodule

//--- tb/tb_fdos_top.sv
// Purpose: self-checking bench for fdos_top
// Assumes: ticks every cycle, so start-up takes about 265k cycles
// Notes: expected pulse counts come from the divide ratios
`timescale 1ns/1ns
module tb_fdos_top;
	reg clk = 1'b0, srst = 1'b1, chip_sleep_n = 1'b1, reset_n = 1'b1, b_slow = 1'b0;
	reg output_align_request_n = 1'b1, cal_ok = 1'b1;
	reg [7:0] soft_ctrl = 8'hff, out_enable = 8'hff;
	reg [3:0] frac_out_divider_en = 4'h0;
	reg [1:0] bypass_sel = 2'h0, bypass_src = 2'h0;
	reg [35:0] int_div = {4{9'h004}};
	reg [79:0] frac_word = 80'h0;
	wire ref_en, feedback_clock, pfd_en, prescaler_a, prescaler_b, pri_ref, sec_ref;
	wire divider_hold, cal_active, cal_failed, status_pin_zero;
	wire [7:0] clk_out, clk_oe_n;
	wire [7:0] int_tick = {8{pri_ref}};
	integer error_cnt = 0, samples_checked = 0, cyc = 0, n, c4, c5, c6, i, f, s;
	logic [31:0] exp_q[$];
	logic [31:0] obs_q[$];
	string       nm_q[$];
	always #5 clk = ~clk;
	fdos_far_model far (
		.clk            (clk),
		.b_slow         (b_slow),
		.ref_en         (ref_en),
		.feedback_clock (feedback_clock),
		.pfd_en         (pfd_en),
		.prescaler_a    (prescaler_a),
		.prescaler_b    (prescaler_b),
		.pri_ref        (pri_ref),
		.sec_ref        (sec_ref)
	);
	fdos_top DUT (
		.clk                    (clk),
		.srst                   (srst),
		.chip_sleep_n           (chip_sleep_n),
		.reset_n                (reset_n),
		.output_align_request_n (output_align_request_n),
		.soft_ctrl              (soft_ctrl),
		.ref_en                 (ref_en),
		.feedback_clock         (feedback_clock),
		.pfd_en                 (pfd_en),
		.cal_ok                 (cal_ok),
		.prescaler_a            (prescaler_a),
		.prescaler_b            (prescaler_b),
		.int_tick               (int_tick),
		.pri_ref                (pri_ref),
		.sec_ref                (sec_ref),
		.frac_out_divider_en    (frac_out_divider_en),
		.int_div                (int_div),
		.frac_word              (frac_word),
		.bypass_sel             (bypass_sel),
		.bypass_src             (bypass_src),
		.out_enable             (out_enable),
		.clk_out                (clk_out),
		.clk_oe_n               (clk_oe_n),
		.divider_hold           (divider_hold),
		.cal_active             (cal_active),
		.cal_failed             (cal_failed),
		.status_pin_zero        (status_pin_zero)
	);
	task complete_run;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
		samples_checked++;
		if (seen !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task note(input string nm, input logic [31:0] seen, input logic [31:0] e);
		exp_q.push_back(e);
		obs_q.push_back(seen);
		nm_q.push_back(nm);
		@(negedge clk);
	endtask
	// Oldest note is compared at the first edge after it was taken
	always @(posedge clk) begin
		if (exp_q.size() > 0)
			check(nm_q.pop_front(), obs_q.pop_front(), exp_q.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 300000) begin
			error_cnt++;
			complete_run;
		end
	end
	task pulses(input integer len);
		c4 = 0;
		c5 = 0;
		c6 = 0;
		repeat (len) begin
			@(posedge clk);
			#1 c4 = c4 + clk_out[4];
			c5 = c5 + clk_out[5];
			c6 = c6 + clk_out[6];
		end
		@(negedge clk);
	endtask
	task sync_pulse(input logic pin);
		if (pin) output_align_request_n = 1'b0;
		else soft_ctrl = 8'hdf;
		repeat (4) @(negedge clk);
		note("oe_n in sync", clk_oe_n, 8'hff);
		note("hold in sync", divider_hold, 1'b1);
		output_align_request_n = 1'b1;
		soft_ctrl = 8'hff;
		repeat (8) @(negedge clk);
		note("oe_n after sync", clk_oe_n, 8'h00);
	endtask
	initial begin
		s = $urandom(32'h0f3c);
		repeat (16) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		note("oe_n at reset", clk_oe_n, 8'hff);
		for (n = 0; cal_active !== 1'b1 && n < 140000; n++) @(negedge clk);
		note("boot wait", n > 131069 && n < 131075, 1);
		for (n = 0; cal_active === 1'b1 && n < 140000; n++) @(negedge clk);
		note("cal length", n > 131070 && n < 131075, 1);
		for (; status_pin_zero !== 1'b1 && n < 134000; n++) @(negedge clk);
		note("lock delay", n - 131072 > 2040 && n - 131072 < 2570, 1);
		note("oe_n after cal", clk_oe_n, 8'h00);
		note("cal failed flag", cal_failed, 1'b0);
		sync_pulse(1'b1);
		sync_pulse(1'b0);
		// host disables output 2 alone
		out_enable = 8'hfb;
		repeat (3) @(negedge clk);
		note("oe_n one off", clk_oe_n, 8'h04);
		out_enable = 8'hff;
		i = 2 + $urandom % 254;
		// lane 2 fraction parts stop at .875
		f = $urandom % 32'he0001;
		// lanes 1 and 3 on the integer path
		frac_out_divider_en = 4'h5;
		frac_word = {20'h0, f[19:0], 20'h0, 20'h80000};
		int_div = {9'h004, i[8:0], 9'h004, 9'h004};
		b_slow = 1'b1;
		sync_pulse(1'b1);
		pulses(900);
		note("out4 pulses", c4 > 198 && c4 < 202, 1);
		note("out5 pulses", c5 > 448 && c5 < 452, 1);
		s = (64'd450 << 20) / (i * 64'd1048576 + f);
		note("out6 pulses", c6 >= s - 1 && c6 <= s + 1, 1);
		bypass_sel = 2'h1;
		for (n = 0; n < 2; n++) begin
			bypass_src = n[1:0];
			repeat (4) @(negedge clk);
			pulses(400);
			s = n ? 100 : 200;
			note("bypass pulses", c4 >= s - 2 && c4 <= s + 2, 1);
		end
		// reset pin toggle restarts the sequence mid-run
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		note("oe_n after restart", clk_oe_n, 8'hff);
		note("lock after restart", status_pin_zero, 1'b0);
		note("cal after restart", cal_active, 1'b0);
		complete_run;
	end
endmodule
